// ### logic/emp_pkg.sv
package emp_pkg;
  // pin and word widths
  localparam int PADDR_W = 22;
  localparam int LADDR_W = 24;
  localparam int BUS_W   = 16;
  localparam int WORD_W  = 24;
  localparam int AXI_AW  = 4;

  // register byte offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_BOOT = 4'h4;
  localparam logic [3:0] OFF_STAT = 4'h8;
  localparam logic [3:0] OFF_FLAG = 4'hC;

  // control register fields
  localparam int CTRL_BUS16   = 0;
  localparam int CTRL_FMT24   = 1;
  localparam int CTRL_WMS_LO  = 2;
  localparam int CTRL_WCNT_LO = 4;
  localparam int CTRL_HALF    = 8;

  // boot enable register fields
  localparam int BOOT_INSTR = 0;
  localparam int BOOT_PROG  = 1;
  localparam int BOOT_DATA  = 2;

  // flag register fields
  localparam int FLAG_OE_LO = 8;
  localparam int FLAG_IN_LO = 16;

  // values after reset: 16-bit bus, count-only waits, no boot override
  localparam logic [31:0] CTRL_RST = 32'h0000_0005;
  localparam logic [31:0] BOOT_RST = 32'h0000_0000;
  localparam logic [31:0] FLAG_RST = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    EMP_FETCH = 2'h0,
    EMP_PDATA = 2'h1,
    EMP_DDATA = 2'h2,
    EMP_IO    = 2'h3
  } emp_kind_e;

  typedef enum logic [1:0] {
    EMP_WMS_ACK    = 2'h0,
    EMP_WMS_COUNT  = 2'h1,
    EMP_WMS_BOTH   = 2'h2,
    EMP_WMS_EITHER = 2'h3
  } emp_wms_e;

  typedef enum logic [4:0] {
    EMP_IDLE   = 5'h01,
    EMP_SETUP  = 5'h02,
    EMP_STROBE = 5'h04,
    EMP_HOLD   = 5'h08,
    EMP_GRANT  = 5'h10
  } emp_state_e;

  // one core word request
  typedef struct packed {
    logic                write;
    emp_kind_e           kind;
    logic                wide;
    logic [LADDR_W-1:0]  laddr;
    logic [WORD_W-1:0]   wdata;
  } emp_req_s;
endpackage

// ### logic/emp_port.sv
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module emp_port #(
  parameter int WAIT_W = 4
) (
  input  logic                             aclk,
  input  logic                             aresetn,
  input  logic [emp_pkg::AXI_AW-1:0]       s_axi_awaddr,
  input  logic                             s_axi_awvalid,
  output logic                             s_axi_awready,
  input  logic [31:0]                      s_axi_wdata,
  input  logic [3:0]                       s_axi_wstrb,
  input  logic                             s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  logic                             s_axi_bready,
  input  logic [emp_pkg::AXI_AW-1:0]       s_axi_araddr,
  input  logic                             s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  logic                             s_axi_rready,
  input  logic                             req_valid,
  input  emp_pkg::emp_req_s                req,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic [emp_pkg::WORD_W-1:0]       rsp_rdata,
  output logic [emp_pkg::PADDR_W-1:0]      ext_addr_out,
  output logic [emp_pkg::BUS_W-1:0]        ext_data_o,
  input  logic [emp_pkg::BUS_W-1:0]        ext_data_i,
  output logic                             ext_data_oe_lo,
  output logic                             ext_data_oe_hi,
  output logic [3:0]                       bank_select_n,
  output logic                             boot_space_select_n,
  output logic                             io_space_select_n,
  output logic                             rd_n,
  output logic                             wr_n,
  input  logic                             ack,
  output logic                             bus_drive_oe,
  input  logic                             bus_request_n,
  output logic                             bus_grant_n,
  output logic                             ext_clock_out
);
  initial begin
    if (WAIT_W < 1 || WAIT_W > 4) begin
      $error("WAIT_W must lie in 1..4");
    end
  end

  logic [31:0]               ctrl_reg;
  logic [31:0]               boot_reg;
  logic [31:0]               flag_reg;
  logic [emp_pkg::AXI_AW-1:0] aw_addr_reg;
  logic [31:0]               w_data_reg;
  logic [3:0]                w_strb_reg;
  emp_pkg::emp_state_e       state_reg;
  emp_pkg::emp_req_s         cur_reg;
  logic                      bus16_reg;
  logic                      x24_reg;
  logic                      trunc_reg;
  logic [1:0]                shf_reg;
  logic [1:0]                ncyc_reg;
  logic [1:0]                cyc_reg;
  logic [WAIT_W-1:0]         cnt_reg;
  logic [emp_pkg::WORD_W-1:0] acc_reg;
  logic                      ph_reg;

  // configuration fields
  logic              cfg_bus16;
  logic              cfg_fmt24;
  emp_pkg::emp_wms_e cfg_wms;
  logic [WAIT_W-1:0] cfg_wcnt;
  assign cfg_bus16 = ctrl_reg[emp_pkg::CTRL_BUS16];
  assign cfg_fmt24 = ctrl_reg[emp_pkg::CTRL_FMT24];
  assign cfg_wms   = emp_pkg::emp_wms_e'(ctrl_reg[emp_pkg::CTRL_WMS_LO+:2]);
  assign cfg_wcnt  = ctrl_reg[emp_pkg::CTRL_WCNT_LO+:WAIT_W];

  // byte-enable merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i+:8] = nw[8*i+:8];
      end
    end
    return r;
  endfunction

  // physical address of one bus cycle; upper bits are simply cut off
  function automatic logic [emp_pkg::PADDR_W-1:0] phys(
      input logic [emp_pkg::LADDR_W-1:0] la,
      input logic [1:0] sh,
      input logic [1:0] off);
    logic [emp_pkg::LADDR_W+2:0] p;
    p = ({3'h0, la} << sh) + {25'h0, off};
    return p[emp_pkg::PADDR_W-1:0];
  endfunction

  // bus lanes of one cycle for the word being written
  function automatic logic [15:0] lane(input logic [23:0] w,
                                       input logic [1:0]  c,
                                       input logic        b16,
                                       input logic        x24);
    logic [15:0] r;
    r = 16'h0000;
    if (!b16) begin
      r = {8'h00, w[8*c+:8]};
    end else if (!x24) begin
      r = w[15:0];
    end else if (c == 2'h0) begin
      r = {w[7:0], 8'h00};
    end else begin
      r = w[23:8];
    end
    return r;
  endfunction

  // decode of the incoming request against current settings
  logic        n_x24;
  logic        n_trunc;
  logic        n_data;
  logic [1:0]  n_shf;
  logic [1:0]  n_ncyc;
  logic        n_boot;
  logic [23:0] n_xw;
  always_comb begin
    n_data  = req.kind == emp_pkg::EMP_PDATA ||
              req.kind == emp_pkg::EMP_DDATA;
    n_x24   = req.kind == emp_pkg::EMP_FETCH ||
              (n_data && req.wide && cfg_fmt24);
    n_trunc = n_data && req.wide && !cfg_fmt24;
    n_xw    = n_trunc ? {8'h00, req.wdata[23:8]} : req.wdata;
    n_shf   = {1'b0, !n_x24 && !req.wide && cfg_fmt24 &&
               req.kind != emp_pkg::EMP_FETCH} +
              (n_x24 ? 2'h1 : 2'h0) + (cfg_bus16 ? 2'h0 : 2'h1);
    n_ncyc  = cfg_bus16 ? (n_x24 ? 2'h2 : 2'h1) :
                          (n_x24 ? 2'h3 : 2'h2);
    n_boot  = (req.kind == emp_pkg::EMP_FETCH &&
               boot_reg[emp_pkg::BOOT_INSTR]) ||
              (req.kind == emp_pkg::EMP_PDATA &&
               boot_reg[emp_pkg::BOOT_PROG]) ||
              (req.kind == emp_pkg::EMP_DDATA &&
               boot_reg[emp_pkg::BOOT_DATA]);
  end

  // lanes of the first cycle and of the following cycle; kept as
  // nets because a select of a function result is not legal
  logic [15:0] lane_first;
  logic [15:0] lane_next;
  assign lane_first = lane(n_xw, 2'h0, cfg_bus16, n_x24);
  assign lane_next  = lane(cur_reg.wdata, cyc_reg + 2'h1,
                           bus16_reg, x24_reg);

  // access end condition per waitstate mode
  logic done;
  always_comb begin
    done = 1'b0;
    unique case (cfg_wms)
      emp_pkg::EMP_WMS_ACK:    done = ack;
      emp_pkg::EMP_WMS_COUNT:  done = cnt_reg >= cfg_wcnt;
      emp_pkg::EMP_WMS_BOTH:   done = ack && cnt_reg >= cfg_wcnt;
      emp_pkg::EMP_WMS_EITHER: done = ack || cnt_reg >= cfg_wcnt;
    endcase
  end

  logic take;
  logic last;
  assign take = state_reg == emp_pkg::EMP_IDLE && bus_request_n &&
                req_valid && req_ready;
  assign last = cyc_reg == ncyc_reg - 2'h1;

  // external access sequencer; bus width and format are latched per word, waitstate mode and count are read live
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg           <= emp_pkg::EMP_IDLE;
      cur_reg             <= '0;
      bus16_reg           <= 1'b0;
      x24_reg             <= 1'b0;
      trunc_reg           <= 1'b0;
      shf_reg             <= 2'h0;
      ncyc_reg            <= 2'h1;
      cyc_reg             <= 2'h0;
      cnt_reg             <= '0;
      acc_reg             <= 24'h000000;
      req_ready           <= 1'b0;
      rsp_valid           <= 1'b0;
      rsp_rdata           <= 24'h000000;
      ext_addr_out        <= 22'h000000;
      ext_data_o          <= 16'h0000;
      ext_data_oe_lo      <= 1'b0;
      ext_data_oe_hi      <= 1'b0;
      bank_select_n       <= 4'hF;
      boot_space_select_n <= 1'b1;
      io_space_select_n   <= 1'b1;
      rd_n                <= 1'b1;
      wr_n                <= 1'b1;
      bus_drive_oe        <= 1'b1;
      bus_grant_n         <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state_reg)
        emp_pkg::EMP_IDLE: begin
          if (!bus_request_n) begin
            state_reg    <= emp_pkg::EMP_GRANT;
            req_ready    <= 1'b0;
            bus_drive_oe <= 1'b0;
            bus_grant_n  <= 1'b0;
          end else if (take) begin
            cur_reg       <= req;
            cur_reg.wdata <= n_xw;
            bus16_reg     <= cfg_bus16;
            x24_reg       <= n_x24;
            trunc_reg     <= n_trunc;
            shf_reg       <= n_shf;
            ncyc_reg      <= n_ncyc;
            cyc_reg       <= 2'h0;
            req_ready     <= 1'b0;
            ext_addr_out <= phys(req.laddr, n_shf,
                                 {1'b0, !cfg_bus16 && n_x24});
            ext_data_o[7:0] <= lane_first[7:0];
            ext_data_oe_lo  <= req.write;
            if (cfg_bus16) begin
              ext_data_o[15:8] <= lane_first[15:8];
              ext_data_oe_hi   <= req.write;
            end
            // select decode, same packing all spaces
            if (req.kind == emp_pkg::EMP_IO) begin
              io_space_select_n <= 1'b0;
            end else if (n_boot) begin
              boot_space_select_n <= 1'b0;
            end else begin
              bank_select_n[req.laddr[23:22]] <= 1'b0;
            end
            state_reg <= emp_pkg::EMP_SETUP;
          end else begin
            req_ready <= 1'b1;
          end
        end
        emp_pkg::EMP_SETUP: begin
          rd_n      <= cur_reg.write;
          wr_n      <= !cur_reg.write;
          cnt_reg   <= '0;
          state_reg <= emp_pkg::EMP_STROBE;
        end
        emp_pkg::EMP_STROBE: begin
          if (cnt_reg != '1) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
          if (done) begin
            rd_n      <= 1'b1;
            wr_n      <= 1'b1;
            state_reg <= emp_pkg::EMP_HOLD;
            if (!cur_reg.write) begin
              if (!bus16_reg) begin
                acc_reg[8*cyc_reg+:8] <= ext_data_i[7:0];
              end else if (!x24_reg) begin
                acc_reg[15:0] <= ext_data_i;
              end else if (cyc_reg == 2'h0) begin
                acc_reg[7:0] <= ext_data_i[15:8];
              end else begin
                acc_reg[23:8] <= ext_data_i;
              end
            end
          end
        end
        emp_pkg::EMP_HOLD: begin
          if (last) begin
            bank_select_n       <= 4'hF;
            boot_space_select_n <= 1'b1;
            io_space_select_n   <= 1'b1;
            ext_data_oe_lo      <= 1'b0;
            ext_data_oe_hi      <= 1'b0;
            rsp_valid           <= 1'b1;
            // low byte lost on narrow format
            rsp_rdata <= trunc_reg ? {acc_reg[15:0], 8'h00} : acc_reg;
            state_reg <= emp_pkg::EMP_IDLE;
          end else begin
            cyc_reg      <= cyc_reg + 2'h1;
            ext_addr_out <= phys(cur_reg.laddr, shf_reg,
                                 cyc_reg + 2'h1 +
                                 {1'b0, !bus16_reg && x24_reg});
            ext_data_o[7:0] <= lane_next[7:0];
            if (bus16_reg) begin
              ext_data_o[15:8] <= lane_next[15:8];
            end
            state_reg <= emp_pkg::EMP_SETUP;
          end
        end
        emp_pkg::EMP_GRANT: begin
          if (bus_request_n) begin
            bus_drive_oe <= 1'b1;
            bus_grant_n  <= 1'b1;
            state_reg    <= emp_pkg::EMP_IDLE;
          end
        end
      endcase
      // upper lines become flags on narrow bus
      if (!cfg_bus16 && state_reg != emp_pkg::EMP_GRANT) begin
        ext_data_o[15:8] <= flag_reg[7:0];
        ext_data_oe_hi   <= flag_reg[emp_pkg::FLAG_OE_LO];
      end
    end
  end

  // clock pin; half rate toggles on every other edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_reg        <= 1'b0;
      ext_clock_out <= 1'b0;
    end else begin
      ph_reg <= !ph_reg;
      if (!ctrl_reg[emp_pkg::CTRL_HALF] || ph_reg) begin
        ext_clock_out <= !ext_clock_out;
      end
    end
  end

  // axi write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= emp_pkg::RESP_OKAY;
      aw_addr_reg   <= '0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      ctrl_reg      <= emp_pkg::CTRL_RST;
      boot_reg      <= emp_pkg::BOOT_RST;
      flag_reg      <= emp_pkg::FLAG_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= emp_pkg::RESP_OKAY;
        unique case ({aw_addr_reg[3:2], 2'h0})
          emp_pkg::OFF_CTRL:
            ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg);
          emp_pkg::OFF_BOOT:
            boot_reg <= merge(boot_reg, w_data_reg, w_strb_reg) &
                        32'h0000_0007;
          emp_pkg::OFF_FLAG:
            flag_reg <= merge(flag_reg, w_data_reg, w_strb_reg) &
                        32'h0000_FFFF;
          default: s_axi_bresp <= emp_pkg::RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // axi read channel; status shows the sequencer's own state
  logic        busy;
  logic [31:0] stat_word;
  assign busy = state_reg != emp_pkg::EMP_IDLE &&
                state_reg != emp_pkg::EMP_GRANT;
  assign stat_word = {27'h0, busy && cur_reg.write, cyc_reg,
                      state_reg == emp_pkg::EMP_GRANT, busy};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= emp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= emp_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[3:2], 2'h0})
        emp_pkg::OFF_CTRL: s_axi_rdata <= ctrl_reg;
        emp_pkg::OFF_BOOT: s_axi_rdata <= boot_reg;
        emp_pkg::OFF_STAT: s_axi_rdata <= stat_word;
        emp_pkg::OFF_FLAG:
          s_axi_rdata <= {8'h00, ext_data_i[15:8], flag_reg[15:0]};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= emp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // checking helpers: strobe rises per word
  logic       ast_strb_q;
  logic [2:0] ast_rises;
  logic       strobe_low;
  logic       any_sel;
  assign strobe_low = !rd_n || !wr_n;
  assign any_sel = bank_select_n != 4'hF || !boot_space_select_n ||
                   !io_space_select_n;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ast_strb_q <= 1'b0;
      ast_rises  <= 3'h0;
    end else begin
      ast_strb_q <= strobe_low;
      if (take) begin
        ast_rises <= 3'h0;
      end else if (ast_strb_q && !strobe_low) begin
        ast_rises <= ast_rises + 3'h1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_sel_up;
    any_sel && !strobe_low;
  endsequence
  sequence seq_strobe_fall;
    $rose(strobe_low);
  endsequence

  AST_STROBE_AFTER_SEL: assert property (
    seq_strobe_fall |-> $past(any_sel) && $stable(ext_addr_out))
    else $error("strobe fell before address and select");
  AST_SEL_WHOLE_ACCESS: assert property (
    strobe_low |-> any_sel ##1 any_sel)
    else $error("select dropped during access");
  AST_IDLE_SEL_OFF: assert property (
    state_reg == emp_pkg::EMP_IDLE |-> !any_sel && !strobe_low)
    else $error("select active with no access");
  AST_BOOT_OVERRIDE: assert property (
    !boot_space_select_n |-> bank_select_n == 4'hF && io_space_select_n)
    else $error("bank select with boot select");
  AST_ACK_EXTENDS: assert property (
    strobe_low && !ack && cfg_wms != emp_pkg::EMP_WMS_COUNT &&
    cfg_wms != emp_pkg::EMP_WMS_EITHER |=> strobe_low)
    else $error("access ended while acknowledge low");
  AST_BYTE_CYCLES: assert property (
    rsp_valid && !bus16_reg |-> ast_rises == (x24_reg ? 3'h3 : 3'h2))
    else $error("wrong cycle count on 8-bit bus");
  AST_WORD_CYCLES: assert property (
    rsp_valid && bus16_reg |-> ast_rises == (x24_reg ? 3'h2 : 3'h1))
    else $error("wrong cycle count on 16-bit bus");
  AST_FLAG_LINES: assert property (
    !cfg_bus16 && $stable(cfg_bus16) && $stable(flag_reg) &&
    state_reg != emp_pkg::EMP_GRANT
    |=> ext_data_o[15:8] == $past(flag_reg[7:0]))
    else $error("upper lines not following flags");
  AST_SETUP_THEN_STROBE: assert property (
    take |=> seq_sel_up ##1 strobe_low)
    else $error("strobe not one cycle after setup");
endmodule // emp_port

// ### testbench/emp_ext_mem.sv
`timescale 1ns/1ps
// asynchronous sram model on the external pins
module emp_ext_mem (
  input  wire logic        aclk,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] data_o,
  output logic [15:0]      data_i,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        slow,
  output logic             ack
);
  logic [15:0] mem [16];
  logic [15:0] last;
  always @(posedge wr_n) mem[addr[3:0]] <= data_o;
  // released bus shows the inverse, so stale data never passes
  always_ff @(posedge aclk) if (!rd_n) last <= mem[addr[3:0]];
  assign data_i = !rd_n ? mem[addr[3:0]] : ~last;
  always_ff @(posedge aclk) ack <= !slow || !rd_n || !wr_n;
endmodule // emp_ext_mem

// ### testbench/ext_mem_port_addr_packing_test.sv
`timescale 1ns/1ps
module ext_mem_port_addr_packing_test;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0;
  logic rready = 0, req_valid = 0, slow = 0, ack, awr, wr, bv, arr, rv;
  logic req_ready, rsp_valid, rd_n, wr_n, bootn;
  logic [3:0] awa = 0, ara = 0, bank_n;
  logic [31:0] wd = 0, rdat;
  logic [1:0] bresp, rresp, r2;
  logic [23:0] rsp, got;
  logic [21:0] addr, seen_addr;
  logic [15:0] dout, din;
  logic [4:0] seen_sel;
  emp_pkg::emp_req_s req = '0;
  int fail_count = 0, samples_checked = 0, cyc = 0;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fail_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
  always #50 aclk = ~aclk;
  emp_port dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rready), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp),
    .ext_addr_out(addr), .ext_data_o(dout), .ext_data_i(din),
    .ext_data_oe_lo(), .ext_data_oe_hi(), .bank_select_n(bank_n),
    .boot_space_select_n(bootn), .io_space_select_n(), .rd_n(rd_n),
    .wr_n(wr_n), .ack(ack), .bus_drive_oe(), .bus_request_n(1'b1),
    .bus_grant_n(), .ext_clock_out());
  emp_ext_mem mem (.aclk(aclk), .addr(addr), .data_o(dout), .data_i(din),
    .rd_n(rd_n), .wr_n(wr_n), .slow(slow), .ack(ack));
  // selects seen while the write strobe is low
  always @(posedge aclk) if (!wr_n) begin
    seen_sel <= {bootn, bank_n};
    seen_addr <= addr;
  end
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    logic aw_d, w_d;
    aw_d = 0;
    w_d = 0;
    awa <= a; wd <= d; awv <= 1; wv <= 1; bready <= 1;
    // each channel is released at the edge where its ready is seen
    do begin
      @(posedge aclk);
      if (awr === 1) aw_d = 1;
      if (wr === 1) w_d = 1;
      if (aw_d) awv <= 0;
      if (w_d) wv <= 0;
    end while (!(aw_d && w_d));
    while (bv !== 1) @(posedge aclk);
    r = bresp;
    bready <= 0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    ara <= a; arv <= 1; rready <= 1;
    do @(posedge aclk); while (arr !== 1);
    arv <= 0;
    while (rv !== 1) @(posedge aclk);
    d = rdat;
    rready <= 0;
    @(posedge aclk);
  endtask
  // one core word; waits for the take, then the end pulse
  task automatic core(input logic w, input emp_pkg::emp_kind_e k,
    input logic wide, input logic [23:0] la, input logic [23:0] d);
    req <= '{write: w, kind: k, wide: wide, laddr: la, wdata: d};
    req_valid <= 1;
    do @(posedge aclk); while (req_ready !== 1);
    req_valid <= 0;
    do @(posedge aclk); while (rsp_valid !== 1);
    got = rsp;
  endtask
  task automatic t_regs;
    logic [31:0] v;
    axr(emp_pkg::OFF_CTRL, v); `CHK("ctrl", emp_pkg::CTRL_RST, v)
    axr(emp_pkg::OFF_BOOT, v); `CHK("boot", emp_pkg::BOOT_RST, v)
    axw(emp_pkg::OFF_STAT, 32'h0000_00FF, r2);
    `CHK("stat wr", emp_pkg::RESP_SLVERR, r2)
  endtask
  task automatic t_bus16;
    axw(emp_pkg::OFF_CTRL, 32'h0000_0007, r2);
    core(1, emp_pkg::EMP_FETCH, 1, 24'h40_0002, 24'h12_3456);
    `CHK("lo half", 16'h5600, mem.mem[4])
    `CHK("hi half", 16'h1234, mem.mem[5])
    `CHK("bank sel", 5'h1D, seen_sel)
    `CHK("phys", 22'h00_0005, seen_addr)
    core(0, emp_pkg::EMP_FETCH, 1, 24'h40_0002, 24'h0);
    `CHK("rd fetch", 24'h12_3456, got)
  endtask
  task automatic t_bus8;
    axw(emp_pkg::OFF_CTRL, 32'h0000_0006, r2);
    core(1, emp_pkg::EMP_FETCH, 1, 24'h00_0001, 24'h12_3456);
    `CHK("b5", 8'h56, mem.mem[5][7:0])
    `CHK("b6", 8'h34, mem.mem[6][7:0])
    `CHK("b7", 8'h12, mem.mem[7][7:0])
    core(0, emp_pkg::EMP_FETCH, 1, 24'h00_0001, 24'h0);
    `CHK("rd8 fetch", 24'h12_3456, got)
    core(1, emp_pkg::EMP_DDATA, 0, 24'h00_0002, 24'h00_ABCD);
    `CHK("b8", 8'hCD, mem.mem[8][7:0])
    `CHK("b9", 8'hAB, mem.mem[9][7:0])
  endtask
  task automatic t_boot;
    slow <= 1;
    axw(emp_pkg::OFF_CTRL, 32'h0000_0001, r2);
    axw(emp_pkg::OFF_BOOT, 32'h0000_0004, r2);
    core(1, emp_pkg::EMP_DDATA, 1, 24'h80_0000, 24'hAB_CDEF);
    `CHK("boot sel", 5'h0F, seen_sel)
    `CHK("boot addr", 22'h0, seen_addr)
    `CHK("trunc", 16'hABCD, mem.mem[0])
    core(0, emp_pkg::EMP_DDATA, 1, 24'h80_0000, 24'h0);
    `CHK("boot rd", 24'hAB_CD00, got)
    slow <= 0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    // no outside master requests the bus here
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs();
    t_bus16();
    t_bus8();
    t_boot();
    report_and_stop();
  end
endmodule // ext_mem_port_addr_packing_test
